// *** src/component_levels_line_type_ctrl.sv ***
// Component level adjust, line-type store and decoder output reference selection.
// Assumes samples arrive one per clock with line and field markers from the sync stage.
// How it works
// - Chroma out is int(saturation/64 times (in minus 128)) plus 128.
// - Luma out is int(contrast/68 times (in minus 128)) plus brightness.
// - Every adjusted luma and chroma result is clamped to 1..254.
// - Contrast, brightness, saturation reset to 44h, 80h, 40h.
// - An ITU 656 style formatter drives the eight-bit expansion data bus.
// - Control signals steer decoder data toward scaler and data slicer.
// - Reference signals are selected for realtime and expansion outputs.
// - Raw and VBI strobes follow the data type of the current line.
// - Registers 41h..56h hold one data type per line count 2..23.
// - The count 24 register covers every remaining line of the field.
// - Upper nibble serves field 1, lower nibble serves field 2.
// - A nine-bit line offset from 5Bh bit 4 and 5Ah shifts line mapping.
// - Field offset bit 5Bh bit 7 adjusts field mapping only, not line mapping.
// - Codes 6 and 15 give component 4:2:2 data, all others raw.
// - The four-bit code names the VBI service of each line.
// - Eleven-bit pixel offset from 5Bh bits 2..0 above 59h.
`timescale 1ns/10ps
`include "levels_cfg.svh"
module component_levels_line_type_ctrl #(
	parameter int LINE_W = 10,
	parameter int PIXEL_W = 11
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Register port
	input wire logic reg_write_in,
	input wire levels_pkg::byte_t reg_addr_in,
	input wire levels_pkg::byte_t reg_wdata_in,
	output levels_pkg::byte_t reg_rdata_out,
	// Component samples in
	input wire logic sample_valid_in,
	input wire logic sample_is_chroma_in,
	input wire levels_pkg::byte_t sample_in,
	// Timing markers from sync stage
	input wire logic line_start_in,
	input wire logic field_start_in,
	input wire logic field_id_in,
	input wire logic href_in,
	input wire logic vgate_in,
	input wire logic v123_in,
	// Paths to scaler and data slicer
	output levels_pkg::byte_t sample_out,
	output logic sample_valid_out,
	output logic raw_type_strobe_out,
	output logic vbi_type_strobe_out,
	output levels_pkg::data_type_t line_data_type_out,
	output logic pixel_window_out,
	// Expansion and realtime ports
	output levels_pkg::byte_t expansion_data_bus_out,
	output logic expansion_horizontal_ref_out,
	output logic expansion_vertical_ref_out,
	output logic expansion_data_qualifier_out,
	output logic realtime_control_out,
	output logic realtime_status_0_out,
	output logic realtime_status_1_out
);
	import levels_pkg::*;

	localparam int NUM_LT = 23;

	byte_t line_type [NUM_LT];
	byte_t pixel_offset_low;
	byte_t line_offset_low;
	byte_t offset_high_and_field;
	byte_t component_contrast;
	byte_t component_brightness;
	byte_t component_saturation;
	byte_t ref_select;

	// Line-type store, one byte per count 2..24
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LT; gi++) begin : g_lt
			wire logic hit = reg_write_in && (reg_addr_in == (`ADDR_LINE_TYPE_FIRST + 8'(gi)));
			always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					line_type[gi] <= `RESET_BYTE;
				end else if (hit) begin
					line_type[gi] <= reg_wdata_in;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pixel_offset_low <= `RESET_BYTE;
			line_offset_low <= `RESET_BYTE;
			offset_high_and_field <= `RESET_BYTE;
			component_contrast <= `RESET_CONTRAST;
			component_brightness <= `RESET_BRIGHTNESS;
			component_saturation <= `RESET_SATURATION;
			ref_select <= `RESET_BYTE;
		end else if (reg_write_in) begin
			case (reg_addr_in)
				`ADDR_PIXEL_OFFSET_LOW: pixel_offset_low <= reg_wdata_in;
				`ADDR_LINE_OFFSET_LOW: line_offset_low <= reg_wdata_in;
				`ADDR_OFFSET_HIGH: offset_high_and_field <= reg_wdata_in;
				`ADDR_CONTRAST: component_contrast <= reg_wdata_in;
				`ADDR_BRIGHTNESS: component_brightness <= reg_wdata_in;
				`ADDR_SATURATION: component_saturation <= reg_wdata_in;
				`ADDR_REF_SELECT: ref_select <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Offsets assembled from split registers
	wire logic [8:0] line_offset = {offset_high_and_field[`BIT_LINE_OFFSET_TOP], line_offset_low};
	wire logic field_offset = offset_high_and_field[`BIT_FIELD_OFFSET];
	wire logic [10:0] pixel_offset = {offset_high_and_field[2:0], pixel_offset_low};

	// Line and pixel counting
	logic [LINE_W-1:0] line_count;
	logic [PIXEL_W-1:0] pixel_count;
	logic field_flag;
	// Field offset swaps which sync field counts as field 1
	wire logic next_field_flag = field_id_in ^ field_offset;
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			line_count <= '0;
			pixel_count <= '0;
			field_flag <= 1'b0;
		end else begin
			if (field_start_in) begin
				line_count <= '0;
				field_flag <= next_field_flag;
			end else if (line_start_in && line_count != '1) begin
				line_count <= line_count + LINE_W'(1);
			end
			if (line_start_in) begin
				pixel_count <= '0;
			end else if (sample_valid_in && pixel_count != '1) begin
				pixel_count <= pixel_count + PIXEL_W'(1);
			end
		end
	end

	// Line count value after offset; below 2 means before count 2
	wire logic signed [LINE_W+1:0] count_value = $signed({2'b00, line_count}) - $signed({3'b000, line_offset})
		+ $signed(12'(`FIRST_COUNT));
	wire logic before_first = count_value < $signed(12'(`FIRST_COUNT));
	wire logic in_rest = count_value >= $signed(12'(`LAST_COUNT));
	wire logic [4:0] lt_index = in_rest ? 5'(`LAST_COUNT - `FIRST_COUNT)
		: 5'(count_value[4:0] - `FIRST_COUNT);
	wire byte_t lt_byte = line_type[lt_index];

	function automatic data_type_t pick_nibble(input byte_t b, input logic field2);
		pick_nibble = field2 ? b[3:0] : b[7:4];
	endfunction : pick_nibble

	function automatic logic is_component(input data_type_t code);
		is_component = (code == `CODE_VBI_COMPONENT) || (code == `CODE_ACTIVE_COMPONENT);
	endfunction : is_component

	// Lines before the first count take the rest-of-field entry too
	wire data_type_t cur_type = before_first ? pick_nibble(line_type[NUM_LT-1], field_flag)
		: pick_nibble(lt_byte, field_flag);
	wire service_e cur_service = service_e'(cur_type);
	wire logic cur_component = is_component(cur_type);
	wire logic cur_vbi = !cur_component && (cur_service != svc_cvbs);
	wire logic in_pixel_window = pixel_count >= PIXEL_W'(pixel_offset);

	// Level arithmetic: 18-bit signed holds 255*127 with margin
	wire logic signed [9:0] centred = $signed({2'b00, sample_in}) - `LEVEL_MID;
	wire logic signed [17:0] luma_prod = $signed({10'h000, component_contrast}) * 18'(centred);
	wire logic signed [17:0] chroma_prod = $signed({10'h000, component_saturation}) * 18'(centred);
	// Signed division truncates toward zero
	wire logic signed [17:0] luma_q = luma_prod / `CONTRAST_DIV;
	wire logic signed [17:0] chroma_q = chroma_prod / `SATURATION_DIV;
	wire logic signed [17:0] luma_sum = luma_q + $signed({10'h000, component_brightness});
	wire logic signed [17:0] chroma_sum = chroma_q + 18'(`LEVEL_MID);
	wire logic signed [17:0] adj_sum = sample_is_chroma_in ? chroma_sum : luma_sum;

	function automatic byte_t clip_level(input logic signed [17:0] v);
		if (v < 18'(`CLIP_MIN)) begin
			clip_level = 8'(`CLIP_MIN);
		end else if (v > 18'(`CLIP_MAX)) begin
			clip_level = 8'(`CLIP_MAX);
		end else begin
			clip_level = v[7:0];
		end
	endfunction : clip_level

	wire byte_t adjusted = clip_level(adj_sum);
	// Raw lines pass the sample untouched, without the 1..254 clamp
	wire byte_t next_sample = cur_component ? adjusted : sample_in;

	// Formatter: timing reference words around active samples
	logic href_d;
	logic [1:0] trs_phase;
	wire logic line_edge = href_in != href_d;
	wire logic eav_flag = !href_in;
	wire byte_t trs_status = {1'b1, field_flag, v123_in, eav_flag,
		v123_in ^ eav_flag, field_flag ^ eav_flag, field_flag ^ v123_in, field_flag ^ v123_in ^ eav_flag};
	wire byte_t trs_byte = (trs_phase == 2'd0) ? 8'hFF : (trs_phase == 2'd3) ? trs_status : 8'h00;
	wire logic trs_busy = trs_phase != 2'd0 || line_edge;
	wire byte_t next_xp = trs_busy ? trs_byte : (href_in ? next_sample : 8'h80);

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			href_d <= 1'b0;
			trs_phase <= 2'd0;
			expansion_data_bus_out <= 8'h80;
		end else begin
			href_d <= href_in;
			if (line_edge || trs_phase != 2'd0) begin
				trs_phase <= trs_phase + 2'd1;
			end
			expansion_data_bus_out <= next_xp;
		end
	end

	// Reference selection: bit pairs choose a source per status pin, bit 4 the vertical ref source
	function automatic logic pick_ref(input logic [1:0] sel, input logic a, input logic b, input logic c,
		input logic d);
		case (sel)
			2'd0: pick_ref = a;
			2'd1: pick_ref = b;
			2'd2: pick_ref = c;
			default: pick_ref = d;
		endcase
	endfunction : pick_ref

	wire logic next_realtime_status_0 = pick_ref(ref_select[1:0], href_in, v123_in, vgate_in, field_flag);
	wire logic next_realtime_status_1 = pick_ref(ref_select[3:2], href_in, v123_in, vgate_in, field_flag);
	wire logic next_xrv = ref_select[4] ? field_flag : v123_in;

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sample_out <= `RESET_BYTE;
			sample_valid_out <= 1'b0;
			raw_type_strobe_out <= 1'b0;
			vbi_type_strobe_out <= 1'b0;
			line_data_type_out <= 4'h0;
			pixel_window_out <= 1'b0;
			expansion_horizontal_ref_out <= 1'b0;
			expansion_vertical_ref_out <= 1'b0;
			expansion_data_qualifier_out <= 1'b0;
			realtime_control_out <= 1'b0;
			realtime_status_0_out <= 1'b0;
			realtime_status_1_out <= 1'b0;
		end else begin
			sample_out <= next_sample;
			sample_valid_out <= sample_valid_in;
			raw_type_strobe_out <= !cur_component;
			vbi_type_strobe_out <= cur_vbi;
			line_data_type_out <= cur_type;
			pixel_window_out <= in_pixel_window;
			expansion_horizontal_ref_out <= href_in;
			expansion_vertical_ref_out <= next_xrv;
			expansion_data_qualifier_out <= href_in && sample_valid_in;
			realtime_control_out <= ref_select[5] && sample_valid_in;
			realtime_status_0_out <= next_realtime_status_0;
			realtime_status_1_out <= next_realtime_status_1;
		end
	end

	// Readback; status byte shows current line state
	wire logic lt_read = reg_addr_in >= `ADDR_LINE_TYPE_FIRST && reg_addr_in <= `ADDR_LINE_TYPE_LAST;
	wire logic [4:0] rd_index = 5'(reg_addr_in - `ADDR_LINE_TYPE_FIRST);
	always_comb begin
		if (lt_read) begin
			reg_rdata_out = line_type[rd_index];
		end else begin
			case (reg_addr_in)
				`ADDR_PIXEL_OFFSET_LOW: reg_rdata_out = pixel_offset_low;
				`ADDR_LINE_OFFSET_LOW: reg_rdata_out = line_offset_low;
				`ADDR_OFFSET_HIGH: reg_rdata_out = offset_high_and_field;
				`ADDR_CONTRAST: reg_rdata_out = component_contrast;
				`ADDR_BRIGHTNESS: reg_rdata_out = component_brightness;
				`ADDR_SATURATION: reg_rdata_out = component_saturation;
				`ADDR_REF_SELECT: reg_rdata_out = ref_select;
				`ADDR_LINE_STATUS: reg_rdata_out = {field_flag, cur_component, cur_vbi, in_rest, cur_type};
				default: reg_rdata_out = `RESET_BYTE;
			endcase
		end
	end
endmodule : component_levels_line_type_ctrl

// *** src/levels_cfg.svh ***
// Register addresses, field positions, reset values and level constants for the component levels block.
// Assumes a byte-wide register port driven by an external two-wire bus slave.
`ifndef LEVELS_CFG_SVH
`define LEVELS_CFG_SVH
`define ADDR_LINE_TYPE_FIRST 8'h41
`define ADDR_LINE_TYPE_LAST 8'h57
`define ADDR_PIXEL_OFFSET_LOW 8'h59
`define ADDR_LINE_OFFSET_LOW 8'h5A
`define ADDR_OFFSET_HIGH 8'h5B
`define ADDR_CONTRAST 8'h5C
`define ADDR_BRIGHTNESS 8'h5D
`define ADDR_SATURATION 8'h5E
`define ADDR_REF_SELECT 8'h5F
`define ADDR_LINE_STATUS 8'h60
`define RESET_CONTRAST 8'h44
`define RESET_BRIGHTNESS 8'h80
`define RESET_SATURATION 8'h40
`define RESET_BYTE 8'h00
`define BIT_FIELD_OFFSET 7
`define BIT_LINE_OFFSET_TOP 4
`define LEVEL_MID 10'sh080
`define CONTRAST_DIV 18'sh00044
`define SATURATION_DIV 18'sh00040
`define CLIP_MIN 10'sh001
`define CLIP_MAX 10'sh0FE
`define FIRST_COUNT 5'h02
`define LAST_COUNT 5'h18
`define CODE_VBI_COMPONENT 4'h6
`define CODE_ACTIVE_COMPONENT 4'hF
`endif

// *** src/levels_pkg.sv ***
// Types shared by the component levels block.
// Assumes the configuration header defines all numeric constants.
package levels_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] data_type_t;
	typedef enum logic [3:0] {
		svc_teletext, svc_euro_caption, svc_vps, svc_widescreen, svc_us_teletext, svc_us_caption,
		svc_vbi_component, svc_cvbs, svc_teletext_b, svc_time_code_eu, svc_time_code_us,
		svc_reserved, svc_nabts, svc_moji, svc_format_switch, svc_active_component
	} service_e;
endpackage : levels_pkg

// *** testbench/slicer_model.sv ***
// Far-side receiver of the scaler and slicer path; keeps the last typed sample.
// Assumes one sample per valid cycle and no back-pressure.
`timescale 1ns/10ps
module slicer_model (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Typed samples
	input wire levels_pkg::byte_t data_in,
	input wire logic valid_in,
	input wire logic raw_in,
	input wire logic vbi_in,
	// Captured values
	output levels_pkg::byte_t last_sample_out,
	output logic last_raw_out,
	output logic last_vbi_out
);
	import levels_pkg::*;
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			last_sample_out <= 8'h00;
			last_raw_out <= 1'b0;
			last_vbi_out <= 1'b0;
		end else if (valid_in) begin
			// Strobes taken with their own sample
			last_sample_out <= data_in;
			last_raw_out <= raw_in;
			last_vbi_out <= vbi_in;
		end
	end
endmodule : slicer_model

// *** testbench/levels_props_props.sv ***
// Port-level checks of the component levels block.
// Assumes a single clock domain; attached by bind.
`timescale 1ns/10ps
`include "levels_cfg.svh"
module levels_props (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Register port
	input wire logic reg_write_in,
	input wire levels_pkg::byte_t reg_addr_in,
	input wire levels_pkg::byte_t reg_wdata_in,
	input wire levels_pkg::byte_t reg_rdata_out,
	// Sample path
	input wire logic sample_valid_in,
	input wire levels_pkg::byte_t sample_in,
	input wire logic href_in,
	input wire levels_pkg::byte_t sample_out,
	input wire logic sample_valid_out,
	input wire logic raw_type_strobe_out,
	input wire logic vbi_type_strobe_out,
	input wire levels_pkg::data_type_t line_data_type_out,
	input wire logic expansion_horizontal_ref_out,
	input wire logic expansion_data_qualifier_out
);
	import levels_pkg::*;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence contrast_write;
		reg_write_in && reg_addr_in == `ADDR_CONTRAST;
	endsequence
	sequence raw_sample;
		sample_valid_in && raw_type_strobe_out ##1 raw_type_strobe_out;
	endsequence
	a_contrast_readback: assert property (contrast_write ##1 reg_addr_in == `ADDR_CONTRAST
		|-> reg_rdata_out == $past(reg_wdata_in)) else $error("contrast readback wrong");
	a_valid_delay: assert property (sample_valid_in |=> sample_valid_out)
		else $error("valid not delayed by one");
	a_raw_passthru: assert property (raw_sample |-> sample_out == $past(sample_in))
		else $error("raw sample altered");
	a_clip_range: assert property (sample_valid_out && !raw_type_strobe_out
		|-> sample_out inside {[8'h01:8'hFE]}) else $error("component sample out of range");
	a_strobe_code: assert property ($past(reset_n_in) |-> raw_type_strobe_out ==
		!(line_data_type_out inside {`CODE_VBI_COMPONENT, `CODE_ACTIVE_COMPONENT})) else $error("raw strobe wrong");
	a_vbi_cvbs: assert property (vbi_type_strobe_out ==
		(raw_type_strobe_out && line_data_type_out != 4'h7)) else $error("vbi strobe wrong");
	a_href_delay: assert property ($rose(href_in) |=> $rose(expansion_horizontal_ref_out))
		else $error("horizontal ref not delayed");
	a_data_qualifier: assert property (href_in && sample_valid_in |=> expansion_data_qualifier_out)
		else $error("qualifier missing");
endmodule : levels_props
bind component_levels_line_type_ctrl levels_props props_u (.ref_clk_in, .reset_n_in, .reg_write_in, .reg_addr_in,
	.reg_wdata_in, .reg_rdata_out, .sample_valid_in, .sample_in, .href_in, .sample_out, .sample_valid_out,
	.raw_type_strobe_out, .vbi_type_strobe_out, .line_data_type_out, .expansion_horizontal_ref_out,
	.expansion_data_qualifier_out);

// *** testbench/testbench.sv ***
// Self-checking bench for the component levels block.
// Assumes the design, its package and header are compiled first.
`timescale 1ns/10ps
`include "levels_cfg.svh"
module testbench;
	import levels_pkg::*;
	typedef struct {logic ch; byte_t con, bri, sat, smp, exp;} row_s;
	logic ref_clk_in = 1'b0, reset_n_in = 1'b0, reg_write_in = 1'b0, sample_valid_in = 1'b0;
	logic sample_is_chroma_in = 1'b0, line_start_in = 1'b0, field_start_in = 1'b0, field_id_in = 1'b0;
	logic href_in = 1'b0, sample_valid_out, raw_type_strobe_out, vbi_type_strobe_out, pixel_window_out;
	logic vgate_in = 1'b0, v123_in = 1'b0;
	logic expansion_horizontal_ref_out, expansion_vertical_ref_out, expansion_data_qualifier_out;
	logic realtime_control_out, realtime_status_0_out, realtime_status_1_out, last_raw, last_vbi, comp;
	byte_t reg_addr_in = 8'h00, reg_wdata_in = 8'h00, sample_in = 8'h00;
	byte_t reg_rdata_out, sample_out, expansion_data_bus_out, last_sample;
	data_type_t line_data_type_out, code;
	int miscompares = 0, num_checks = 0, cycles = 0;
	// Luma rows then chroma rows; truncation toward zero and both clip edges
	row_s rows[10] = '{'{1'b0, 8'h44, 8'h80, 8'h40, 8'hE4, 8'hE4}, '{1'b0, 8'h10, 8'h80, 8'h40, 8'hE4, 8'h97},
		'{1'b0, 8'hFF, 8'h80, 8'h40, 8'hFF, 8'hFE}, '{1'b0, 8'hFF, 8'h80, 8'h40, 8'h00, 8'h01},
		'{1'b0, 8'h44, 8'h00, 8'h40, 8'h64, 8'h01}, '{1'b0, 8'h30, 8'h80, 8'h40, 8'h64, 8'h6D},
		'{1'b1, 8'h44, 8'h80, 8'h40, 8'hC8, 8'hC8}, '{1'b1, 8'h44, 8'h80, 8'hFF, 8'hFF, 8'hFE},
		'{1'b1, 8'h44, 8'h80, 8'h20, 8'h01, 8'h41}, '{1'b1, 8'h44, 8'h80, 8'h00, 8'h32, 8'h80}};
	component_levels_line_type_ctrl dut_u (.ref_clk_in, .reset_n_in, .reg_write_in, .reg_addr_in, .reg_wdata_in,
		.reg_rdata_out, .sample_valid_in, .sample_is_chroma_in, .sample_in, .line_start_in, .field_start_in,
		.field_id_in, .href_in, .vgate_in, .v123_in, .sample_out, .sample_valid_out,
		.raw_type_strobe_out, .vbi_type_strobe_out, .line_data_type_out, .pixel_window_out, .expansion_data_bus_out,
		.expansion_horizontal_ref_out, .expansion_vertical_ref_out, .expansion_data_qualifier_out,
		.realtime_control_out, .realtime_status_0_out, .realtime_status_1_out);
	slicer_model model_u (.ref_clk_in, .reset_n_in, .data_in(sample_out), .valid_in(sample_valid_out),
		.raw_in(raw_type_strobe_out), .vbi_in(vbi_type_strobe_out), .last_sample_out(last_sample),
		.last_raw_out(last_raw), .last_vbi_out(last_vbi));
	task automatic test_done();
		if (miscompares == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	task automatic chk8(input string n, input byte_t e, input byte_t s);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk8
	task automatic chk1(input string n, input logic e, input logic s);
		chk8(n, {7'h00, e}, {7'h00, s});
	endtask : chk1
	task automatic wr(input byte_t a, input byte_t d);
		@(posedge ref_clk_in);
		reg_write_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_write_in <= 1'b0;
	endtask : wr
	task automatic rd(input byte_t a, input byte_t e, input string n);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		#1 chk8(n, e, reg_rdata_out);
	endtask : rd
	// Sample leaves the block one edge later, the model one edge after that
	task automatic smp(input logic ch, input byte_t v);
		@(posedge ref_clk_in);
		sample_valid_in <= 1'b1;
		href_in <= 1'b1;
		sample_is_chroma_in <= ch;
		sample_in <= v;
		@(posedge ref_clk_in);
		sample_valid_in <= 1'b0;
		href_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask : smp
	task automatic fill(input byte_t v);
		for (int a = 0; a < 23; a++)
			wr(`ADDR_LINE_TYPE_FIRST + a[7:0], v);
	endtask : fill
	task automatic new_field(input logic f);
		@(posedge ref_clk_in);
		field_id_in <= f;
		field_start_in <= 1'b1;
		@(posedge ref_clk_in);
		field_start_in <= 1'b0;
		line_start_in <= 1'b1;
		@(posedge ref_clk_in);
		line_start_in <= 1'b0;
	endtask : new_field
	initial begin
		forever #12.5 ref_clk_in = ~ref_clk_in;
	end
	// Whole run needs about 1040 cycles
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		repeat (3) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		rd(`ADDR_CONTRAST, `RESET_CONTRAST, "contrast");
		rd(`ADDR_BRIGHTNESS, `RESET_BRIGHTNESS, "brightness");
		rd(`ADDR_SATURATION, `RESET_SATURATION, "saturation");
		rd(`ADDR_LINE_TYPE_LAST, `RESET_BYTE, "line type last");
		rd(8'h70, 8'h00, "unmapped");
		chk8("idle bus", 8'h80, expansion_data_bus_out);
		fill(8'hFF);
		rd(8'h4C, 8'hFF, "line type mid");
		foreach (rows[i]) begin
			wr(`ADDR_CONTRAST, rows[i].con);
			wr(`ADDR_BRIGHTNESS, rows[i].bri);
			wr(`ADDR_SATURATION, rows[i].sat);
			smp(rows[i].ch, rows[i].smp);
			chk8("level sample", rows[i].exp, last_sample);
		end
		for (int c = 0; c < 16; c++) begin
			code = c[3:0];
			fill({code, code});
			smp(1'b1, 8'h05);
			comp = (code == `CODE_VBI_COMPONENT) || (code == `CODE_ACTIVE_COMPONENT);
			chk8("line type", {4'h0, code}, {4'h0, line_data_type_out});
			chk8("typed sample", comp ? 8'h80 : 8'h05, last_sample);
			chk1("raw strobe", !comp, last_raw);
			chk1("vbi strobe", !comp && code != 4'h7, last_vbi);
		end
		fill(8'hF0);
		wr(`ADDR_LINE_OFFSET_LOW, 8'h06);
		wr(`ADDR_OFFSET_HIGH, 8'h80);
		rd(`ADDR_OFFSET_HIGH, 8'h80, "offset high");
		new_field(1'b1);
		smp(1'b1, 8'h05);
		chk8("swapped field", 8'h80, last_sample);
		wr(`ADDR_OFFSET_HIGH, 8'h00);
		new_field(1'b1);
		smp(1'b1, 8'h05);
		chk8("second field", 8'h05, last_sample);
		wr(`ADDR_PIXEL_OFFSET_LOW, 8'h47);
		rd(`ADDR_PIXEL_OFFSET_LOW, 8'h47, "pixel offset");
		@(posedge ref_clk_in);
		#1 chk1("window before offset", 1'b0, pixel_window_out);
		wr(`ADDR_PIXEL_OFFSET_LOW, 8'h00);
		@(posedge ref_clk_in);
		#1 chk1("window after offset", 1'b1, pixel_window_out);
		// Select vgate on status 0, v123 on status 1, field on vertical ref, valid on control
		wr(`ADDR_REF_SELECT, 8'h36);
		@(posedge ref_clk_in);
		vgate_in <= 1'b1;
		sample_valid_in <= 1'b1;
		@(posedge ref_clk_in);
		sample_valid_in <= 1'b0;
		#1 chk1("status 0 vgate", 1'b1, realtime_status_0_out);
		chk1("status 1 v123", 1'b0, realtime_status_1_out);
		chk1("realtime control", 1'b1, realtime_control_out);
		chk1("vertical ref field", 1'b1, expansion_vertical_ref_out);
		// Reset in mid-run restores the level defaults
		@(posedge ref_clk_in);
		reset_n_in <= 1'b0;
		@(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		rd(`ADDR_CONTRAST, `RESET_CONTRAST, "contrast after reset");
		rd(`ADDR_SATURATION, `RESET_SATURATION, "saturation after reset");
		test_done();
	end
endmodule : testbench
